// ===== design/mmpc_defs.vh
// Constants of the memory map position control block.
`ifndef MMPC_DEFS_VH
`define MMPC_DEFS_VH

// ****************************************************************
// Register indexes; the byte offset inside the block is four times the index.
// ****************************************************************
`define MMPC_IDX_RAM_POS       5'h10
`define MMPC_IDX_REGBLK_POS    5'h11
`define MMPC_IDX_EEPROM_POS    5'h12
`define MMPC_IDX_MISC          5'h13

// ****************************************************************
// Field layouts and reset values.
// ****************************************************************
`define MMPC_RAM_POS_RESET     8'h09
`define MMPC_RAM_WMASK         8'hF9
`define MMPC_REGBLK_WMASK      8'h78
`define MMPC_EE_BASE_WMASK     8'hF8
`define MMPC_EE_EN_BIT         0
`define MMPC_BASE_HI           7
`define MMPC_BASE_LO           3
`define MMPC_ALIGN_BIT         0
`define MMPC_REGBLK_HI         6
`define MMPC_STRETCH_HI        3
`define MMPC_STRETCH_LO        2
`define MMPC_UHO_BIT           1
`define MMPC_FLASH_EN_BIT      0
`define MMPC_MISC_LEN          4
`define MMPC_STRETCH_RESET     2'h3
`define MMPC_UHO_RESET         1'h0

// ****************************************************************
// Fixed address spaces.
// ****************************************************************
`define MMPC_ADDR_W            16
`define MMPC_BASE_SHIFT        11
`define MMPC_FLASH_LOW_BASE    16'h4000
`define MMPC_FLASH_WIN_BASE    16'h8000
`define MMPC_FLASH_HIGH_BASE   16'hC000
`define MMPC_FLASH_PAGE_MASK   16'hC000

// ****************************************************************
// Bus answers.
// ****************************************************************
`define MMPC_RESP_OKAY         2'h0
`define MMPC_RESP_SLVERR       2'h2

`endif

// ===== design/mmpc_window.v
// Address window compare used by the map decoder.
`timescale 1ns/100ps
module mmpc_window #(
   parameter AW = 16
) (
   input  wire [AW-1:0] addr,
   input  wire [AW-1:0] base,
   input  wire [AW-1:0] mask,
   output wire          hit
);

   assign hit = ((addr & mask) == (base & mask));

endmodule // mmpc_window

// ===== design/mmpc_field.v
// One control field with optional lock set by the first write outside special mode, and delayed mapping copy.
`timescale 1ns/100ps
module mmpc_field #(
   parameter W        = 8,
   parameter LOCKABLE = 1
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [W-1:0] reset_value,
   input  wire         wr_en,
   input  wire [W-1:0] wr_data,
   input  wire         special_mode,
   output reg  [W-1:0] value_reg,
   output reg  [W-1:0] active_reg
);

   reg lock_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         value_reg  <= reset_value;
         active_reg <= reset_value;
         lock_reg   <= 1'b0;
      end else begin
         active_reg <= value_reg;
         if (wr_en && !(LOCKABLE != 0 && lock_reg)) begin
            value_reg <= wr_data;
         end
         if (wr_en && LOCKABLE != 0 && !special_mode) begin
            lock_reg <= 1'b1;
         end
      end
   end

endmodule // mmpc_field

// ===== design/mmpc_top.v
// Memory map position control registers with AXI4-Lite access and map decoder.
`timescale 1ns/100ps
`include "mmpc_defs.vh"
module mmpc_top #(
   parameter       RAM_REGION_LOG2   = 11,
   parameter       RAM_SIZE_BYTES    = 2048,
   parameter       REG_BLOCK_LOG2    = 11,
   parameter       EEPROM_LOG2       = 11,
   parameter       EE_BASE_ONCE      = 0,
   parameter [7:0] REGBLK_POS_RESET  = 8'h00,
   parameter [7:0] EEPROM_POS_RESET  = 8'h00
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [15:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [15:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        special_mode,
   input  wire        single_chip_or_periph_mode,
   input  wire        special_test_mode,
   input  wire        flash_enable_strap,
   input  wire [15:0] core_addr,
   output reg         ram_select,
   output reg         regs_select,
   output reg         eeprom_select,
   output reg         flash_select,
   output reg         flash_page_window,
   output reg         external_select,
   output reg  [1:0]  stretch_cycles
);

   // ****************************************************************
   // Write channel capture.
   // ****************************************************************
   reg  [15:0] aw_addr_reg;
   reg         aw_have_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         w_have_reg;
   wire        wr_go;
   wire [7:0]  wbyte;
   wire        wlane;

   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go         = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wbyte         = w_data_reg[7:0];
   assign wlane         = w_strb_reg[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_reg <= 16'h0000;
         aw_have_reg <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         w_have_reg  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
         end else if (wr_go) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_have_reg <= 1'b1;
         end else if (wr_go) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Register decode relative to the active register block base.
   // ****************************************************************
   wire [3:0]  regblk_active;
   wire [4:0]  regblk_base5;
   reg         w_hit;
   reg  [4:0]  w_idx;
   reg         r_hit;
   reg  [4:0]  r_idx;

   assign regblk_base5 = {1'b0, regblk_active};

   always @* begin
      w_hit = (aw_addr_reg[15:`MMPC_BASE_SHIFT] == regblk_base5)
              && (aw_addr_reg[10:7] == 4'h0) && (aw_addr_reg[1:0] == 2'h0);
      w_idx = aw_addr_reg[6:2];
      if (w_idx != `MMPC_IDX_RAM_POS && w_idx != `MMPC_IDX_REGBLK_POS
          && w_idx != `MMPC_IDX_EEPROM_POS && w_idx != `MMPC_IDX_MISC) begin
         w_hit = 1'b0;
      end
      r_hit = (s_axi_araddr[15:`MMPC_BASE_SHIFT] == regblk_base5)
              && (s_axi_araddr[10:7] == 4'h0) && (s_axi_araddr[1:0] == 2'h0);
      r_idx = s_axi_araddr[6:2];
      if (r_idx != `MMPC_IDX_RAM_POS && r_idx != `MMPC_IDX_REGBLK_POS
          && r_idx != `MMPC_IDX_EEPROM_POS && r_idx != `MMPC_IDX_MISC) begin
         r_hit = 1'b0;
      end
   end

   wire wr_ram    = wr_go && w_hit && wlane && (w_idx == `MMPC_IDX_RAM_POS);
   wire wr_regblk = wr_go && w_hit && wlane && (w_idx == `MMPC_IDX_REGBLK_POS);
   wire wr_ee     = wr_go && w_hit && wlane && (w_idx == `MMPC_IDX_EEPROM_POS);
   wire wr_misc   = wr_go && w_hit && wlane && (w_idx == `MMPC_IDX_MISC);

   // ****************************************************************
   // Control fields.
   // ****************************************************************
   wire [7:0] ram_pos_value;
   wire [7:0] ram_pos_active;
   wire [3:0] regblk_value;
   wire [4:0] ee_base_value;
   wire [4:0] ee_base_active;
   wire       ee_en_value;
   wire       ee_en_active;
   wire [3:0] misc_value;
   wire [3:0] misc_active;
   reg        flash_en_reset;
   wire [3:0] misc_reset;

   always @* begin
      if (single_chip_or_periph_mode) begin
         flash_en_reset = 1'b1;
      end else if (special_test_mode) begin
         flash_en_reset = 1'b0;
      end else begin
         flash_en_reset = flash_enable_strap;
      end
   end

   assign misc_reset = {`MMPC_STRETCH_RESET, `MMPC_UHO_RESET, flash_en_reset};

   mmpc_field #(.W(8), .LOCKABLE(1)) u_ram_pos (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .reset_value  (`MMPC_RAM_POS_RESET),
      .wr_en        (wr_ram),
      .wr_data      (wbyte & `MMPC_RAM_WMASK),
      .special_mode (special_mode),
      .value_reg    (ram_pos_value),
      .active_reg   (ram_pos_active)
   );

   mmpc_field #(.W(4), .LOCKABLE(1)) u_regblk_pos (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .reset_value  (REGBLK_POS_RESET[`MMPC_REGBLK_HI:`MMPC_BASE_LO]),
      .wr_en        (wr_regblk),
      .wr_data      (wbyte[`MMPC_REGBLK_HI:`MMPC_BASE_LO]),
      .special_mode (special_mode),
      .value_reg    (regblk_value),
      .active_reg   (regblk_active)
   );

   mmpc_field #(.W(5), .LOCKABLE(EE_BASE_ONCE)) u_ee_base (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .reset_value  (EEPROM_POS_RESET[`MMPC_BASE_HI:`MMPC_BASE_LO]),
      .wr_en        (wr_ee),
      .wr_data      (wbyte[`MMPC_BASE_HI:`MMPC_BASE_LO]),
      .special_mode (special_mode),
      .value_reg    (ee_base_value),
      .active_reg   (ee_base_active)
   );

   mmpc_field #(.W(1), .LOCKABLE(0)) u_ee_en (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .reset_value  (EEPROM_POS_RESET[`MMPC_EE_EN_BIT]),
      .wr_en        (wr_ee),
      .wr_data      (wbyte[`MMPC_EE_EN_BIT]),
      .special_mode (special_mode),
      .value_reg    (ee_en_value),
      .active_reg   (ee_en_active)
   );

   mmpc_field #(.W(`MMPC_MISC_LEN), .LOCKABLE(1)) u_misc (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .reset_value  (misc_reset),
      .wr_en        (wr_misc),
      .wr_data      (wbyte[`MMPC_MISC_LEN-1:0]),
      .special_mode (special_mode),
      .value_reg    (misc_value),
      .active_reg   (misc_active)
   );

   // ****************************************************************
   // Write response.
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MMPC_RESP_OKAY;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? `MMPC_RESP_OKAY : `MMPC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************
   reg [7:0] rbyte;

   always @* begin
      case (r_idx)
         `MMPC_IDX_RAM_POS: begin
            rbyte = ram_pos_value;
         end
         `MMPC_IDX_REGBLK_POS: begin
            rbyte = {1'b0, regblk_value, 3'h0};
         end
         `MMPC_IDX_EEPROM_POS: begin
            rbyte = {ee_base_value, 2'h0, ee_en_value};
         end
         `MMPC_IDX_MISC: begin
            rbyte = {4'h0, misc_value};
         end
         default: begin
            rbyte = 8'h00;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `MMPC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= r_hit ? {24'h000000, rbyte} : 32'h00000000;
            s_axi_rresp  <= r_hit ? `MMPC_RESP_OKAY : `MMPC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Memory map decode from the active copies.
   // ****************************************************************
   localparam [15:0] RAM_REGION_MASK = ~((16'h0001 << RAM_REGION_LOG2) - 16'h0001);
   localparam [15:0] RAM_REGION_SIZE = 16'h0001 << RAM_REGION_LOG2;
   localparam [15:0] RAM_SIZE        = RAM_SIZE_BYTES[15:0];
   localparam [15:0] REG_BLOCK_MASK  = ~((16'h0001 << REG_BLOCK_LOG2) - 16'h0001);
   localparam [15:0] EEPROM_MASK     = ~((16'h0001 << EEPROM_LOG2) - 16'h0001);

   wire [15:0] ram_region_base;
   wire [15:0] ram_offset;
   wire        ram_region_hit;
   wire        ram_hit;
   wire        regs_hit;
   wire        ee_window_hit;
   wire        ee_hit;
   wire        flash_low_page;
   wire        flash_hit;
   wire        win_hit;

   assign ram_region_base = {ram_pos_active[`MMPC_BASE_HI:`MMPC_BASE_LO], 11'h000} & RAM_REGION_MASK;
   assign ram_offset      = core_addr - ram_region_base;

   mmpc_window #(.AW(`MMPC_ADDR_W)) u_ram_region (
      .addr (core_addr),
      .base (ram_region_base),
      .mask (RAM_REGION_MASK),
      .hit  (ram_region_hit)
   );

   assign ram_hit = ram_region_hit && (ram_pos_active[`MMPC_ALIGN_BIT]
                    ? (ram_offset >= (RAM_REGION_SIZE - RAM_SIZE))
                    : (ram_offset < RAM_SIZE));

   mmpc_window #(.AW(`MMPC_ADDR_W)) u_regs (
      .addr (core_addr),
      .base ({regblk_base5, 11'h000}),
      .mask (REG_BLOCK_MASK),
      .hit  (regs_hit)
   );

   mmpc_window #(.AW(`MMPC_ADDR_W)) u_eeprom (
      .addr (core_addr),
      .base ({ee_base_active, 11'h000}),
      .mask (EEPROM_MASK),
      .hit  (ee_window_hit)
   );

   assign ee_hit = ee_en_active && ee_window_hit;

   assign win_hit        = (core_addr & `MMPC_FLASH_PAGE_MASK) == `MMPC_FLASH_WIN_BASE;
   assign flash_low_page = (core_addr & `MMPC_FLASH_PAGE_MASK) == `MMPC_FLASH_LOW_BASE;
   assign flash_hit      = misc_active[`MMPC_FLASH_EN_BIT] && (win_hit
                           || ((core_addr & `MMPC_FLASH_PAGE_MASK) == `MMPC_FLASH_HIGH_BASE)
                           || (flash_low_page && !misc_active[`MMPC_UHO_BIT]));

   always @(posedge aclk) begin
      if (!aresetn) begin
         ram_select        <= 1'b0;
         regs_select       <= 1'b0;
         eeprom_select     <= 1'b0;
         flash_select      <= 1'b0;
         flash_page_window <= 1'b0;
         external_select   <= 1'b0;
         stretch_cycles    <= 2'h0;
      end else begin
         regs_select       <= regs_hit;
         ram_select        <= !regs_hit && ram_hit;
         eeprom_select     <= !regs_hit && !ram_hit && ee_hit;
         flash_select      <= !regs_hit && !ram_hit && !ee_hit && flash_hit;
         flash_page_window <= !regs_hit && !ram_hit && !ee_hit && flash_hit && win_hit;
         external_select   <= !single_chip_or_periph_mode && !regs_hit && !ram_hit && !ee_hit && !flash_hit;
         if (single_chip_or_periph_mode) begin
            stretch_cycles <= 2'h0;
         end else begin
            stretch_cycles <= misc_active[`MMPC_STRETCH_HI:`MMPC_STRETCH_LO];
         end
      end
   end

endmodule // mmpc_top

// ===== dv/mmpc_checker_sva.sv
// Assertion checker for the memory map position control registers.
`timescale 1ns/100ps
`include "mmpc_defs.vh"
module mmpc_checker (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        single_chip_or_periph_mode,
   input logic [15:0] core_addr,
   input logic        regs_select,
   input logic        flash_page_window,
   input logic [1:0]  stretch_cycles
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************************************
   // Bus handshake sequences.
   // ****************************************************************
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
      else $error("write response not given two cycles after the transfer");
   chk_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
      else $error("read data not valid one cycle after the address");
   chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while a response is pending");
   chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while read data is pending");
   chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
   chk_error_data: assert property (s_axi_rvalid && s_axi_rresp == `MMPC_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
      else $error("error read returned data");
   chk_regs_low: assert property (regs_select |-> $past(core_addr) < 16'h8000)
      else $error("register block selected above the first half");
   chk_window_half: assert property (flash_page_window |-> $past(core_addr) >= 16'h8000 && $past(core_addr) < 16'hC000)
      else $error("page window flagged outside its range");
   chk_stretch_off: assert property (single_chip_or_periph_mode [*2] |=> stretch_cycles == 2'h0)
      else $error("stretch applied in single chip mode");
endmodule // mmpc_checker

bind mmpc_top mmpc_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .single_chip_or_periph_mode(single_chip_or_periph_mode), .core_addr(core_addr), .regs_select(regs_select),
   .flash_page_window(flash_page_window), .stretch_cycles(stretch_cycles));

// ===== dv/memory_map_position_control_bench.sv
// Self-checking bench of the memory map position control registers.
`timescale 1ns/100ps
`include "mmpc_defs.vh"
module memory_map_position_control_bench;
   localparam [4:0] I_RAM = `MMPC_IDX_RAM_POS;
   localparam [4:0] I_RB  = `MMPC_IDX_REGBLK_POS;
   localparam [4:0] I_EE  = `MMPC_IDX_EEPROM_POS;
   localparam [4:0] I_MI  = `MMPC_IDX_MISC;
   localparam [1:0] OK    = `MMPC_RESP_OKAY;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg         special_mode, single_chip_or_periph_mode, special_test_mode, flash_enable_strap;
   reg  [15:0] s_axi_awaddr, s_axi_araddr, core_addr, rb;
   reg  [31:0] s_axi_wdata;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire        ram_select, regs_select, eeprom_select, flash_select, flash_page_window, external_select;
   wire [1:0]  s_axi_bresp, s_axi_rresp, stretch_cycles;
   wire [31:0] s_axi_rdata;
   integer     failures, checks_done;

   mmpc_top #(.RAM_SIZE_BYTES(1024)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .special_mode(special_mode), .single_chip_or_periph_mode(single_chip_or_periph_mode),
      .special_test_mode(special_test_mode), .flash_enable_strap(flash_enable_strap), .core_addr(core_addr),
      .ram_select(ram_select), .regs_select(regs_select), .eeprom_select(eeprom_select),
      .flash_select(flash_select), .flash_page_window(flash_page_window), .external_select(external_select),
      .stretch_cycles(stretch_cycles));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task end_of_test;
      begin
         $display("checks %0d failures %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task check(input string name, input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task step(inout integer n);
      begin
         @(posedge aclk);
         n = n + 1;
         if (n > 40) begin
            failures = failures + 1;
            end_of_test;
         end
      end
   endtask
   function [15:0] ra(input [4:0] idx);
      ra = rb + {9'h000, idx, 2'h0};
   endfunction
   task wr(input [15:0] a, input [7:0] d);
      integer n;
      begin
         n = 0;
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h000000, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            step(n);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         check("bresp", {30'h0, s_axi_bresp}, {30'h0, OK});
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [31:0] exp, input [1:0] resp);
      integer n;
      begin
         n = 0;
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            step(n);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         check("rdata", s_axi_rdata, exp);
         check("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
         s_axi_rready <= 1'b0;
      end
   endtask
   task sel(input [15:0] a);
      begin
         @(posedge aclk);
         core_addr <= a;
         repeat (2) @(posedge aclk);
         #1;
      end
   endtask
   task reset_dut(input sp, input sc, input st);
      begin
         @(posedge aclk);
         aresetn <= 1'b0;
         special_mode <= sp;
         single_chip_or_periph_mode <= sc;
         special_test_mode <= st;
         rb = 16'h0000;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
      end
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task test_reset;
      begin
         reset_dut(1'b0, 1'b0, 1'b0);
         rd(ra(I_RAM), 32'h09, OK);
         rd(ra(I_RB), 32'h00, OK);
         rd(ra(I_EE), 32'h00, OK);
         rd(ra(I_MI), 32'h0D, OK);
         rd(16'h0050, 32'h00, `MMPC_RESP_SLVERR);
         check("stretch", {30'h0, stretch_cycles}, 32'h3);
         sel(16'h0800);
         check("ram_sel", {31'h0, ram_select}, 32'h0);
         sel(16'h0C00);
         check("ram_sel", {31'h0, ram_select}, 32'h1);
         sel(16'h0000);
         check("regs_sel", {31'h0, regs_select}, 32'h1);
         sel(16'hC000);
         check("flash_sel", {31'h0, flash_select}, 32'h1);
         $display("test reset done");
      end
   endtask
   task test_write_once;
      begin
         sel(16'h2400);
         wr(ra(I_RAM), 8'h21);
         #1;
         check("ram_sel", {31'h0, ram_select}, 32'h0);
         @(posedge aclk);
         #1;
         check("ram_sel", {31'h0, ram_select}, 32'h1);
         wr(ra(I_RAM), 8'h31);
         rd(ra(I_RAM), 32'h21, OK);
         wr(ra(I_MI), 8'h06);
         wr(ra(I_MI), 8'h0F);
         rd(ra(I_MI), 32'h06, OK);
         check("stretch", {30'h0, stretch_cycles}, 32'h1);
         sel(16'hC000);
         check("ext_sel", {31'h0, external_select}, 32'h1);
         wr(ra(I_RB), 8'h10);
         rb = 16'h1000;
         rd(16'h0044, 32'h00, `MMPC_RESP_SLVERR);
         wr(ra(I_RB), 8'h18);
         rd(ra(I_RB), 32'h10, OK);
         wr(ra(I_EE), 8'h31);
         sel(16'h3000);
         check("ee_sel", {31'h0, eeprom_select}, 32'h1);
         wr(ra(I_EE), 8'h38);
         sel(16'h3800);
         check("ee_sel", {31'h0, eeprom_select}, 32'h0);
         rd(ra(I_EE), 32'h38, OK);
         $display("test write once done");
      end
   endtask
   task test_special;
      begin
         reset_dut(1'b1, 1'b0, 1'b1);
         rd(ra(I_MI), 32'h0C, OK);
         wr(ra(I_MI), 8'h09);
         rd(ra(I_MI), 32'h09, OK);
         check("stretch", {30'h0, stretch_cycles}, 32'h2);
         wr(ra(I_MI), 8'hFF);
         rd(ra(I_MI), 32'h0F, OK);
         sel(16'h4000);
         check("flash_sel", {31'h0, flash_select}, 32'h0);
         sel(16'h8000);
         check("page_win", {31'h0, flash_page_window}, 32'h1);
         wr(ra(I_MI), 8'h0D);
         sel(16'h4000);
         check("flash_sel", {31'h0, flash_select}, 32'h1);
         wr(ra(I_RAM), 8'hF8);
         sel(16'hF800);
         check("ram_sel", {31'h0, ram_select}, 32'h1);
         sel(16'hFC00);
         check("ram_sel", {31'h0, ram_select}, 32'h0);
         wr(ra(I_RAM), 8'h41);
         rd(ra(I_RAM), 32'h41, OK);
         wr(ra(I_RB), 8'hF8);
         rb = 16'h7800;
         rd(ra(I_RB), 32'h78, OK);
         sel(16'h7800);
         check("regs_sel", {31'h0, regs_select}, 32'h1);
         $display("test special done");
      end
   endtask
   task test_single;
      begin
         flash_enable_strap <= 1'b0;
         reset_dut(1'b0, 1'b1, 1'b0);
         rd(ra(I_MI), 32'h0D, OK);
         check("stretch", {30'h0, stretch_cycles}, 32'h0);
         reset_dut(1'b0, 1'b0, 1'b0);
         rd(ra(I_MI), 32'h0C, OK);
         $display("test single chip done");
      end
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      aresetn = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 16'h0000;
      s_axi_araddr = 16'h0000;
      s_axi_wdata = 32'h00000000;
      core_addr = 16'h0000;
      special_mode = 1'b0;
      single_chip_or_periph_mode = 1'b0;
      special_test_mode = 1'b0;
      flash_enable_strap = 1'b1;
      rb = 16'h0000;
      failures = 0;
      checks_done = 0;
      test_reset;
      test_write_once;
      test_special;
      test_single;
      end_of_test;
   end
endmodule // memory_map_position_control_bench
